// ===== common/tsoa_pkg.sv
// package: register map, control fields and defaults of the stream offset alignment block
package tsoa_pkg;
  // register groups, address bits [11:6]; stream index in bits [5:2]
  localparam logic [5:0] TSOA_GRP_CTRL = 6'h00;
  localparam logic [5:0] TSOA_GRP_LCD = 6'h01;
  localparam logic [5:0] TSOA_GRP_BCD = 6'h02;
  localparam logic [5:0] TSOA_GRP_LID = 6'h03;
  localparam logic [5:0] TSOA_GRP_BID = 6'h04;
  localparam logic [5:0] TSOA_GRP_LOA = 6'h05;
  localparam logic [5:0] TSOA_GRP_BOA = 6'h06;
  localparam logic [3:0] TSOA_IDX_CTRL = 4'h0;
  localparam logic [3:0] TSOA_IDX_STATUS = 4'h1;
  // control and status register field positions
  localparam int TSOA_CTRL_EN_BIT = 0;
  localparam int TSOA_CTRL_MODE_LSB = 1;
  localparam int TSOA_CTRL_SMPL_BIT = 4;
  localparam int TSOA_CTRL_LHR_BIT = 5;
  localparam int TSOA_CTRL_BHR_BIT = 6;
  localparam int TSOA_STAT_LOCK_BIT = 16;
  // reset values
  localparam logic [6:0] TSOA_CTRL_RST = 7'h00;
  localparam logic [4:0] TSOA_IN_DELAY_RST = 5'h00;
  localparam logic [1:0] TSOA_ADV_RST = 2'h0;
  // discriminator mode codes
  localparam logic [2:0] TSOA_MODE_LOW_ONLY = 3'h0;
  localparam logic [2:0] TSOA_MODE_LOW_HIGH = 3'h7;
  // timing: quarter-bit ticks per bit, quarter ticks per channel (8 bits)
  localparam int TSOA_CH_SHIFT = 5;
  localparam logic [1:0] TSOA_DEFAULT_PHASE = 2'h3;
  localparam int TSOA_HR_STREAMS = 8;
endpackage : tsoa_pkg

// ===== rtl/tsoa_stream_align.sv
// stream offset alignment: input channel/bit delay, sampling point, output advance
// Summary of operation
// - discriminator runs only when enable bit set
// - mode 000 low jitter, 111 low+high jitter
// - reserved modes; mode ignored while disabled
// - channel plus bit delay, quarter-bit resolution
// - per-stream channel delay from frame pulse
// - channel delay resets to zero
// - sample mode low: quarter-bit delay up to 7.75
// - sample mode high: low bits pick point
// - sample mode high: upper bits integer delay
// - per-stream output advance before frame boundary
// - low rates advance 0,2,4,6 clocks
// - high rate advance 0,1,2,3 clocks
// - inputs aligned to master pulse and clock
// - high-rate mode uses first eight streams only
`timescale 1ns/100ps
module tsoa_stream_align import tsoa_pkg::*; #(
  parameter int NS = 16,
  parameter int CW = 9,
  parameter int TW = 16,
  parameter int FRAME_TICKS = 2048,
  parameter int WIN_TICKS = 4,
  parameter int MISS_MAX = 3,
  parameter int LW = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic master_clock_in_i,
  input wire logic master_frame_pulse_in_n_i,
  output logic generated_frame_pulse_out_n_o,
  output logic discriminator_locked_o,
  output logic [NS-1:0] local_in_ch0_o,
  output logic [NS-1:0] local_in_sample_o,
  output logic [NS-1:0] back_in_ch0_o,
  output logic [NS-1:0] back_in_sample_o,
  output logic [NS-1:0] local_out_align_o,
  output logic [NS-1:0] back_out_align_o
);
  typedef enum logic [0:0] {
    TSOA_HUNT = 1'b0,
    TSOA_LOCK = 1'b1
  } tsoa_disc_type;

  typedef struct packed {
    logic [2:0] mck_sync;
    logic [2:0] fp_sync;
    logic mck_stb;
    logic fp_stb;
    tsoa_disc_type disc;
    logic [1:0] miss;
    logic [TW-1:0] tick;
    logic [LW-1:0] cyc;
    logic [LW-1:0] flen;
    logic discriminator_enable;
    logic [2:0] discriminator_mode_sel;
    logic sample_point_mode_sel;
    logic local_high_rate_mode;
    logic back_high_rate_mode;
    logic [1:0][NS-1:0][CW-1:0] chan_delay;
    logic [1:0][NS-1:0][4:0] in_delay;
    logic [1:0][NS-1:0][1:0] out_adv;
    logic [31:0] rdata;
    logic fpo_n;
    logic [1:0][NS-1:0] in_ch0;
    logic [1:0][NS-1:0] in_smp;
    logic [1:0][NS-1:0] out_al;
  } tsoa_state_type;

  tsoa_state_type st_r;
  tsoa_state_type st_nxt;

  logic mck_ev;
  logic fp_fall;
  logic boundary;
  logic in_win;
  logic [5:0] grp;
  logic [3:0] idx;
  logic [TW-1:0] start;
  logic [TW-1:0] rel;
  logic [1:0] phase;
  logic [2:0] adv_cyc;
  logic hr;

  always_comb begin
    st_nxt = st_r;
    grp = addr_i[11:6];
    idx = addr_i[5:2];
    // loop temporaries get a value on every path, so no latch is inferred
    hr = 1'b0;
    start = '0;
    rel = '0;
    phase = 2'd0;
    adv_cyc = 3'd0;

    // only stable, agreeing samples count as a pin change
    st_nxt.mck_sync = {st_r.mck_sync[1:0], master_clock_in_i};
    st_nxt.fp_sync = {st_r.fp_sync[1:0], master_frame_pulse_in_n_i};
    mck_ev = 1'b0;
    fp_fall = 1'b0;
    if (st_r.mck_sync[1] == st_r.mck_sync[2] && st_r.mck_sync[2] != st_r.mck_stb) begin
      st_nxt.mck_stb = st_r.mck_sync[2];
      mck_ev = 1'b1;
    end
    if (st_r.fp_sync[1] == st_r.fp_sync[2] && st_r.fp_sync[2] != st_r.fp_stb) begin
      st_nxt.fp_stb = st_r.fp_sync[2];
      fp_fall = ~st_r.fp_sync[2];
    end

    // frame tick counter, one tick per master clock edge (quarter bit)
    // the window straddles the expected wrap, before and after it
    in_win = (int'(st_r.tick) >= FRAME_TICKS - WIN_TICKS) || (int'(st_r.tick) < WIN_TICKS);
    boundary = 1'b0;
    if (mck_ev) begin
      if (int'(st_r.tick) == FRAME_TICKS - 1) begin
        st_nxt.tick = '0;
        boundary = 1'b1;
      end else begin
        st_nxt.tick = st_r.tick + TW'(1);
      end
    end
    if (fp_fall) begin
      if (!st_r.discriminator_enable) begin
        st_nxt.tick = '0;
        boundary = 1'b1;
        st_nxt.disc = TSOA_HUNT;
      end else if (st_r.discriminator_mode_sel != TSOA_MODE_LOW_HIGH) begin
        // low-frequency tracking only: every pulse realigns
        st_nxt.tick = '0;
        boundary = 1'b1;
        st_nxt.disc = TSOA_LOCK;
        st_nxt.miss = '0;
      end else begin
        case (st_r.disc)
          TSOA_HUNT: begin
            st_nxt.tick = '0;
            boundary = 1'b1;
            st_nxt.disc = TSOA_LOCK;
            st_nxt.miss = '0;
          end
          TSOA_LOCK: begin
            // outliers are high-frequency jitter; flywheel over them
            if (in_win) begin
              if (int'(st_r.tick) >= FRAME_TICKS - WIN_TICKS) begin
                boundary = 1'b1;
              end
              st_nxt.tick = '0;
              st_nxt.miss = '0;
            end else if (int'(st_r.miss) == MISS_MAX - 1) begin
              st_nxt.disc = TSOA_HUNT;
              st_nxt.miss = '0;
            end else begin
              st_nxt.miss = st_r.miss + 2'd1;
            end
          end
          default: st_nxt.disc = TSOA_HUNT;
        endcase
      end
    end
    if (!st_r.discriminator_enable) begin
      st_nxt.disc = TSOA_HUNT;
    end

    // frame length in system clocks, for advancing outputs
    if (boundary) begin
      st_nxt.cyc = '0;
      st_nxt.flen = st_r.cyc + LW'(1);
    end else begin
      st_nxt.cyc = st_r.cyc + LW'(1);
    end
    // one-cycle low pulse at each accepted or flywheel boundary
    st_nxt.fpo_n = ~boundary;

    // both ports share one frame counter; only delays, advances and the high-rate mode differ
    for (int p = 0; p < 2; p++) begin
      hr = (p == 0) ? st_r.local_high_rate_mode : st_r.back_high_rate_mode;
      for (int s = 0; s < NS; s++) begin
        start = TW'({st_r.chan_delay[p][s], {TSOA_CH_SHIFT{1'b0}}});
        if (!st_r.sample_point_mode_sel) begin
          start = start + TW'(st_r.in_delay[p][s]);
          phase = TSOA_DEFAULT_PHASE;
        end else begin
          start = start + TW'({st_r.in_delay[p][s][4:2], 2'b00});
          case (st_r.in_delay[p][s][1:0])
            2'b00: phase = 2'd3;
            2'b01: phase = 2'd0;
            2'b10: phase = 2'd1;
            2'b11: phase = 2'd2;
            default: phase = 2'd3;
          endcase
        end
        rel = st_nxt.tick - start;
        if (hr) begin
          adv_cyc = {1'b0, st_r.out_adv[p][s]};
        end else begin
          adv_cyc = {st_r.out_adv[p][s], 1'b0};
        end
        if (hr && s >= TSOA_HR_STREAMS) begin
          st_nxt.in_ch0[p][s] = 1'b0;
          st_nxt.in_smp[p][s] = 1'b0;
          st_nxt.out_al[p][s] = 1'b0;
        end else begin
          st_nxt.in_ch0[p][s] = mck_ev && (st_nxt.tick == start);
          st_nxt.in_smp[p][s] = mck_ev && (rel[1:0] == phase);
          // no measured frame yet means no advanced pulse in the first frame
          if (adv_cyc == 3'd0) begin
            st_nxt.out_al[p][s] = boundary;
          end else begin
            st_nxt.out_al[p][s] = !boundary &&
              (st_nxt.cyc == st_r.flen - LW'(adv_cyc));
          end
        end
      end
    end

    // register port
    // read data stands for one cycle only and is zero otherwise
    st_nxt.rdata = '0;
    // a stream index beyond the stream count has no register behind it
    if (wr_i) begin
      case (grp)
        TSOA_GRP_CTRL: begin
          if (idx == TSOA_IDX_CTRL) begin
            st_nxt.discriminator_enable = wdata_i[TSOA_CTRL_EN_BIT];
            st_nxt.discriminator_mode_sel = wdata_i[TSOA_CTRL_MODE_LSB +: 3];
            st_nxt.sample_point_mode_sel = wdata_i[TSOA_CTRL_SMPL_BIT];
            st_nxt.local_high_rate_mode = wdata_i[TSOA_CTRL_LHR_BIT];
            st_nxt.back_high_rate_mode = wdata_i[TSOA_CTRL_BHR_BIT];
          end
        end
        TSOA_GRP_LCD: st_nxt.chan_delay[0][idx] = wdata_i[CW-1:0];
        TSOA_GRP_BCD: st_nxt.chan_delay[1][idx] = wdata_i[CW-1:0];
        TSOA_GRP_LID: st_nxt.in_delay[0][idx] = wdata_i[4:0];
        TSOA_GRP_BID: st_nxt.in_delay[1][idx] = wdata_i[4:0];
        TSOA_GRP_LOA: st_nxt.out_adv[0][idx] = wdata_i[1:0];
        TSOA_GRP_BOA: st_nxt.out_adv[1][idx] = wdata_i[1:0];
        default: ;
      endcase
    end
    if (rd_i) begin
      case (grp)
        TSOA_GRP_CTRL: begin
          if (idx == TSOA_IDX_CTRL) begin
            st_nxt.rdata[TSOA_CTRL_EN_BIT] = st_r.discriminator_enable;
            st_nxt.rdata[TSOA_CTRL_MODE_LSB +: 3] = st_r.discriminator_mode_sel;
            st_nxt.rdata[TSOA_CTRL_SMPL_BIT] = st_r.sample_point_mode_sel;
            st_nxt.rdata[TSOA_CTRL_LHR_BIT] = st_r.local_high_rate_mode;
            st_nxt.rdata[TSOA_CTRL_BHR_BIT] = st_r.back_high_rate_mode;
          end else if (idx == TSOA_IDX_STATUS) begin
            st_nxt.rdata[TW-1:0] = st_r.tick;
            st_nxt.rdata[TSOA_STAT_LOCK_BIT] = (st_r.disc == TSOA_LOCK);
          end
        end
        TSOA_GRP_LCD: st_nxt.rdata[CW-1:0] = st_r.chan_delay[0][idx];
        TSOA_GRP_BCD: st_nxt.rdata[CW-1:0] = st_r.chan_delay[1][idx];
        TSOA_GRP_LID: st_nxt.rdata[4:0] = st_r.in_delay[0][idx];
        TSOA_GRP_BID: st_nxt.rdata[4:0] = st_r.in_delay[1][idx];
        TSOA_GRP_LOA: st_nxt.rdata[1:0] = st_r.out_adv[0][idx];
        TSOA_GRP_BOA: st_nxt.rdata[1:0] = st_r.out_adv[1][idx];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      // pin stages start high; the frame pulse idles high, so no false fall
      st_r.mck_sync <= 3'b111;
      st_r.fp_sync <= 3'b111;
      st_r.mck_stb <= 1'b1;
      st_r.fp_stb <= 1'b1;
      st_r.disc <= TSOA_HUNT;
      st_r.discriminator_enable <= TSOA_CTRL_RST[TSOA_CTRL_EN_BIT];
      st_r.chan_delay <= '0;
      st_r.in_delay <= {2 * NS{TSOA_IN_DELAY_RST}};
      st_r.out_adv <= {2 * NS{TSOA_ADV_RST}};
      st_r.fpo_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = st_r.rdata;
  assign generated_frame_pulse_out_n_o = st_r.fpo_n;
  assign discriminator_locked_o = (st_r.disc == TSOA_LOCK);
  assign local_in_ch0_o = st_r.in_ch0[0];
  assign local_in_sample_o = st_r.in_smp[0];
  assign back_in_ch0_o = st_r.in_ch0[1];
  assign back_in_sample_o = st_r.in_smp[1];
  assign local_out_align_o = st_r.out_al[0];
  assign back_out_align_o = st_r.out_al[1];
endmodule : tsoa_stream_align

// ===== tb/tsoa_checker.sv
// assertion checker for the stream offset alignment block
`timescale 1ns/100ps
module tsoa_checker import tsoa_pkg::*; #(
  parameter int NS = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic generated_frame_pulse_out_n_o,
  input wire logic discriminator_locked_o,
  input wire logic [NS-1:0] local_in_ch0_o,
  input wire logic [NS-1:0] local_in_sample_o,
  input wire logic [NS-1:0] local_out_align_o,
  input wire logic [NS-1:0] back_in_ch0_o,
  input wire logic [NS-1:0] back_out_align_o
);
  // shadow of the control word, seen only through the register port
  logic [6:0] ctrl_r;
  logic [6:0] ctrl_nxt;
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_i && addr_i == 12'h000) ctrl_nxt = wdata_i[6:0];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) ctrl_r <= TSOA_CTRL_RST;
    else ctrl_r <= ctrl_nxt;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_lock_off;
    !ctrl_r[0] && !$past(ctrl_r[0]) |-> !discriminator_locked_o;
  endproperty
  a_lock_off: assert property (p_lock_off) else $error("locked while disabled");
  property p_ctrl_rb;
    rd_i && addr_i == 12'h000 |=> rdata_o == {25'h0, $past(ctrl_r)};
  endproperty
  a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback wrong");
  // two cycles of mode so registered pulses already follow it
  property p_hr_local;
    ctrl_r[5] && $past(ctrl_r[5]) |-> ((local_in_ch0_o | local_out_align_o) >> 8) == '0;
  endproperty
  a_hr_local: assert property (p_hr_local) else $error("local stream above 7 active");
  property p_hr_back;
    ctrl_r[6] && $past(ctrl_r[6]) |-> ((back_in_ch0_o | back_out_align_o) >> 8) == '0;
  endproperty
  a_hr_back: assert property (p_hr_back) else $error("back stream above 7 active");
  property p_fp;
    !generated_frame_pulse_out_n_o |=> generated_frame_pulse_out_n_o [*3];
  endproperty
  a_fp: assert property (p_fp) else $error("frame pulse too long");
  property p_ch0;
    local_in_ch0_o[0] |=> !local_in_ch0_o[0] [*3];
  endproperty
  a_ch0: assert property (p_ch0) else $error("channel start pulse too close");
  property p_smp;
    local_in_sample_o[0] |=> !local_in_sample_o[0] [*3];
  endproperty
  a_smp: assert property (p_smp) else $error("sample pulses too close");
  property p_align;
    local_out_align_o[0] |=> !local_out_align_o[0];
  endproperty
  a_align: assert property (p_align) else $error("advance pulse too long");
  c_lock: cover property (discriminator_locked_o);
  c_back_align: cover property (back_out_align_o[0]);
  c_smp: cover property (local_in_sample_o[0]);
endmodule // tsoa_checker
bind tsoa_stream_align tsoa_checker #(.NS(NS)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .generated_frame_pulse_out_n_o(generated_frame_pulse_out_n_o),
  .discriminator_locked_o(discriminator_locked_o), .local_in_ch0_o(local_in_ch0_o),
  .local_in_sample_o(local_in_sample_o), .local_out_align_o(local_out_align_o),
  .back_in_ch0_o(back_in_ch0_o), .back_out_align_o(back_out_align_o));

// ===== tb/tsoa_link_model.sv
// far-side timing source: free-running master clock and active-low frame pulse
`timescale 1ns/100ps
module tsoa_link_model #(
  parameter int FRAME_TICKS = 64
) (
  output logic master_clock_o,
  output logic frame_pulse_n_o
);
  // every clock change is one quarter-bit tick; 800 ns period
  initial begin
    master_clock_o = 1'b0;
    frame_pulse_n_o = 1'b1;
    forever begin
      for (int t = 0; t < FRAME_TICKS; t++) begin
        if (t == 0) frame_pulse_n_o = 1'b0;
        if (t == 2) frame_pulse_n_o = 1'b1;
        #400;
        master_clock_o = ~master_clock_o;
      end
    end
  end
endmodule // tsoa_link_model

// ===== tb/test_tsoa_stream_align.sv
// self-checking bench for the stream offset alignment block
`timescale 1ns/100ps
module test_tsoa_stream_align import tsoa_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] addr_i = 12'h000;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic mclk, fp_n, fp_out_n, locked;
  logic [15:0] lch0, lsmp, bch0, bsmp, lalg, balg;
  int n_mismatch = 0;
  int num_checks = 0;
  always #50 clk_i = ~clk_i;
  tsoa_link_model #(.FRAME_TICKS(64)) u_far (.master_clock_o(mclk), .frame_pulse_n_o(fp_n));
  tsoa_stream_align #(.FRAME_TICKS(64)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .master_clock_in_i(mclk),
    .master_frame_pulse_in_n_i(fp_n), .generated_frame_pulse_out_n_o(fp_out_n),
    .discriminator_locked_o(locked), .local_in_ch0_o(lch0), .local_in_sample_o(lsmp),
    .back_in_ch0_o(bch0), .back_in_sample_o(bsmp), .local_out_align_o(lalg),
    .back_out_align_o(balg));
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [5:0] g, input logic [3:0] i, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= {g, i, 2'b00};
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] g, input logic [3:0] i, input logic [31:0] exp);
    @(posedge clk_i);
    addr_i <= {g, i, 2'b00};
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk("register", rdata_o, exp);
  endtask
  function automatic logic pick(input int k, input int s);
    case (k)
      0: return ~fp_out_n;
      1: return lch0[s];
      2: return lsmp[s];
      3: return lalg[s];
      4: return balg[s];
      5: return bch0[s];
      default: return bsmp[s];
    endcase
  endfunction
  // a lost pulse ends the run instead of hanging
  task automatic wait_on(input int k, input int s, output int n);
    n = 0;
    while (pick(k, s) !== 1'b1 && n < 900) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 900) begin
      n_mismatch++;
      final_report();
    end
  endtask
  // cycles from event ka to the next event kb of stream s
  task automatic gap(input int ka, input int kb, input int s, input int exp);
    int n;
    @(negedge clk_i);
    wait_on(ka, s, n);
    wait_on(kb, s, n);
    chk("pulse distance", 32'(n), 32'(exp));
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(TSOA_GRP_CTRL, TSOA_IDX_CTRL, 32'h0);
    rd(TSOA_GRP_CTRL, TSOA_IDX_STATUS, 32'h0);
    rd(TSOA_GRP_LCD, 4'h3, 32'h0);
    rd(TSOA_GRP_BCD, 4'hf, 32'h0);
    rd(TSOA_GRP_LID, 4'h0, 32'h0);
    wr(6'h3f, 4'h0, 32'hff);
    rd(6'h3f, 4'h0, 32'h0);
    for (int m = 0; m < 8; m++) begin
      wr(TSOA_GRP_CTRL, TSOA_IDX_CTRL, 32'(m * 2 + 1));
      rd(TSOA_GRP_CTRL, TSOA_IDX_CTRL, 32'(m * 2 + 1));
    end
    wr(TSOA_GRP_CTRL, TSOA_IDX_CTRL, {28'h0, TSOA_MODE_LOW_HIGH, 1'b1});
    gap(0, 1, 0, 0);
    chk("lock", {31'h0, locked}, 32'h1);
    gap(1, 2, 0, 12);
    wr(TSOA_GRP_LID, 4'h1, 32'h5);
    gap(0, 1, 1, 20);
    wr(TSOA_GRP_LID, 4'h2, 32'h1f);
    gap(0, 1, 2, 124);
    wr(TSOA_GRP_LCD, 4'h3, 32'h1);
    wr(TSOA_GRP_LID, 4'h3, 32'h2);
    gap(0, 1, 3, 136);
    wr(TSOA_GRP_CTRL, TSOA_IDX_CTRL, 32'h1f);
    for (int c = 0; c < 4; c++) begin
      wr(TSOA_GRP_LID, 4'h0, 32'(8 + c));
      gap(0, 1, 0, 32);
      gap(1, 2, 0, 4 * ((c + 3) % 4));
    end
    for (int k = 0; k < 4; k++) begin
      wr(TSOA_GRP_LOA, 4'h0, 32'(k));
      gap(0, 3, 0, k == 0 ? 0 : 256 - 2 * k);
    end
    wr(TSOA_GRP_CTRL, TSOA_IDX_CTRL, 32'h7f);
    wr(TSOA_GRP_BOA, 4'h9, 32'h3);
    for (int k = 0; k < 4; k++) begin
      wr(TSOA_GRP_BOA, 4'h0, 32'(k));
      gap(0, 4, 0, k == 0 ? 0 : 256 - k);
    end
    rd(TSOA_GRP_BOA, 4'h0, 32'h3);
    wr(TSOA_GRP_CTRL, TSOA_IDX_CTRL, 32'h0e);
    gap(0, 1, 0, 44);
    chk("lock", {31'h0, locked}, 32'h0);
    wr(TSOA_GRP_BCD, 4'h2, 32'h1);
    wr(TSOA_GRP_BID, 4'h2, 32'h6);
    gap(0, 5, 2, 152);
    gap(5, 6, 2, 12);
    final_report();
  end
endmodule // test_tsoa_stream_align
